// File: mbcd_board.sv
// Board model: reference oscillators and the serial freeze sender.
// Assumes the bench holds send until busy rises.
`timescale 1ns/1ps
module mbcd_board (
   // Clock
   input wire logic        sys_clk,
   // Frame request
   input wire logic        send,
   input wire logic [11:0] frame,
   // Pins towards the device
   output logic            serial_shift_clock,
   output logic            serial_in_line,
   output logic            busy,
   output logic [2:0]      refs
);
   ////////////////////////////////////////
   logic [4:0]  tick_q = 5'h00;
   logic [11:0] shift_q = 12'hFFF;
   logic [3:0]  left_q = 4'h0;
   logic        line_q = 1'b1;
   // Free-running serial clock; references at 1/8, 1/16, 1/32
   assign serial_shift_clock = tick_q[2];
   assign refs = tick_q[4:2];
   assign busy = (left_q != 4'h0);
   assign serial_in_line = line_q;
   // Bits change at the serial fall, so each is steady at the rise
   always_ff @(posedge sys_clk) begin
      tick_q <= tick_q + 5'h01;
      if (tick_q[2:0] == 3'h7) begin
         if (busy) begin
            line_q <= shift_q[0];
            shift_q <= {1'b1, shift_q[11:1]};
            left_q <= left_q - 4'h1;
         end else if (send) begin
            line_q <= 1'b0;
            shift_q <= frame;
            left_q <= 4'hC;
         end else begin
            line_q <= 1'b1;
         end
      end
   end
endmodule

// File: mbcd_divider.sv
// One output divider: even-ratio phase counter with a half period
// taken only at the end of a whole period.
// Assumes tick is an enable on sys_clk; each cycle it is high is one step.
`timescale 1ns/1ps
module mbcd_divider (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               run_b,
   // Control
   input  wire logic               tick,
   input  wire mbcd_pkg::mbcd_half_t half_new,
   // Next-state view
   output logic                    level_d,
   output mbcd_pkg::mbcd_per_t     rem_d,
   output mbcd_pkg::mbcd_per_t     per_d
);

   mbcd_pkg::mbcd_half_t half_q;
   mbcd_pkg::mbcd_half_t half_d;
   mbcd_pkg::mbcd_per_t  phase_q;
   mbcd_pkg::mbcd_per_t  phase_d;
   mbcd_pkg::mbcd_per_t  per_q;

   assign per_q = {half_q, 1'b0};

   ////////////////////////////////////////////////////////////////////
   // Ratio is swapped only at a period wrap, so no runt or stretch
   always_comb begin
      phase_d = phase_q;
      half_d  = half_q;
      if (tick) begin
         if (phase_q == per_q - 5'h01) begin
            phase_d = 5'h00;
            half_d  = half_new;
         end else begin
            phase_d = phase_q + 5'h01;
         end
      end
   end

   assign per_d   = {half_d, 1'b0};
   assign level_d = (phase_d < {1'b0, half_d});
   assign rem_d   = per_d - phase_d;

   always_ff @(posedge sys_clk) begin
      if (!run_b) begin
         phase_q <= 5'h00;
         half_q  <= half_new;
      end else begin
         phase_q <= phase_d;
         half_q  <= half_d;
      end
   end

endmodule

// File: mbcd_monitor.sv
// Checker for mbcd_top: timing relations between its pins.
// Assumes a bind to mbcd_top and one sys_clk domain.
`timescale 1ns/1ps
module mbcd_monitor (
   // Clock and reset
   input wire logic                sys_clk,
   input wire logic                rst_b,
   // Straps
   input wire mbcd_pkg::mbcd_sel_s sel_pins,
   input wire logic                master_reset_oe,
   // Watched outputs
   input wire logic [3:0]          bank_a_out,
   input wire logic [3:0]          bank_b_out,
   input wire logic [3:0]          bank_c_out,
   input wire logic                loop_return_out,
   input wire logic                coincidence_pulse_out
);
   ////////////////////////////////////////
   // Cycles since rst_b and master_reset_oe are both high; a reset may legally cut a pulse
   logic [3:0] run_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !master_reset_oe) begin
         run_q <= 4'h0;
      end else if (run_q != 4'hF) begin
         run_q <= run_q + 4'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   a_c1_needs_c0: assert property (bank_c_out[1] |-> bank_c_out[0])
      else $error("C1 high, C0 low");
   a_reset_quiet: assert property (!master_reset_oe [*5] |->
      {bank_a_out, bank_b_out, bank_c_out, loop_return_out} == 13'h0000)
      else $error("output live in reset");
   a_release_run: assert property ($rose(master_reset_oe) |-> ##[3:20] bank_c_out[0])
      else $error("no output after release");
   a_a_high_width: assert property ($rose(bank_a_out[0]) && run_q == 4'hF |->
      bank_a_out[0] [*2])
      else $error("short high on A");
   a_b_low_width: assert property ($fell(bank_b_out[0]) && run_q == 4'hF |->
      !bank_b_out[0] [*2])
      else $error("short low on B");
   a_c2_inverted: assert property (sel_pins.invert_sel [*6] ##0 bank_c_out[2] |->
      !bank_c_out[0])
      else $error("C2 not inverted");
   a_c2_plain: assert property (!sel_pins.invert_sel [*6] ##0 bank_c_out[2] |->
      bank_c_out[0])
      else $error("C2 inverted");
   a_sync_aligned: assert property ($rose(coincidence_pulse_out) && run_q == 4'hF |->
      $rose(bank_c_out[0]))
      else $error("sync rise off C rise");
endmodule
bind mbcd_top mbcd_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b), .sel_pins(sel_pins),
   .master_reset_oe(master_reset_oe), .bank_a_out(bank_a_out), .bank_b_out(bank_b_out),
   .bank_c_out(bank_c_out), .loop_return_out(loop_return_out),
   .coincidence_pulse_out(coincidence_pulse_out));

// File: mbcd_pkg.sv
// Package for the multi-bank clock divider: divide tables, field
// positions and the strap bundle shared by the top and its divider.
// Assumes one system clock that stands in for the VCO.
package mbcd_pkg;

   ////////////////////////////////////////////////////////////////////
   // Widths
   localparam int HALF_W   = 4;
   localparam int PER_W    = 5;
   localparam int NUM_FRZ  = 12;
   localparam int CNT_W    = 4;

   typedef logic [HALF_W-1:0] mbcd_half_t;
   typedef logic [PER_W-1:0]  mbcd_per_t;

   ////////////////////////////////////////////////////////////////////
   // Half periods, in prescaled VCO ticks, per select code
   localparam mbcd_half_t BANK_A_HALF [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
   localparam mbcd_half_t BANK_B_HALF [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
   localparam mbcd_half_t BANK_C_HALF [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
   localparam mbcd_half_t LOOP_HALF   [8] = '{4'h2, 4'h3, 4'h4, 4'h5,
                                              4'h4, 4'h6, 4'h8, 4'hA};

   ////////////////////////////////////////////////////////////////////
   // Freeze bit positions in the serial word
   localparam int FRZ_A_LO = 0;
   localparam int FRZ_B_LO = 4;
   localparam int FRZ_C_LO = 8;
   localparam int FRZ_SYNC = 11;
   localparam logic [NUM_FRZ-1:0] FRZ_RESET = 12'hFFF;
   localparam logic [CNT_W-1:0]   LAST_BIT  = 4'hB;
   localparam logic               START_LVL = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // Strap inputs that travel together
   typedef struct packed {
      logic       vco_halve_sel;
      logic [2:0] loop_ratio_sel;
      logic [1:0] bank_a_sel;
      logic [1:0] bank_b_sel;
      logic [1:0] bank_c_sel;
      logic       invert_sel;
      logic       loop_enable;
      logic       ref_source_sel;
      logic       test_ref_sel;
   } mbcd_sel_s;

   typedef enum logic [1:0] {
      SER_IDLE,
      SER_SHIFT,
      SER_LOAD
   } mbcd_ser_e;

endpackage

// File: mbcd_top.sv
// Control logic of the multi-bank clock divider: reference choice,
// bypass, prescaler, bank and loop dividers, freeze port, sync pulse.
// Assumes sys_clk stands in for the VCO; every pin is asynchronous.
//
// Notes on behaviour
// - VCO multiple set by loop ratio code; here sys_clk is the VCO, the code sets only loop return divide
// - Loop ratio code sets loop return divide
// - Halve select low adds divide by two
// - Each bank picks divider from its select
// - Bank ratio tables, halved when halve high
// - Loop enable low drives dividers from reference
// - Source select high picks differential reference
// - Test select picks reference zero or one
// - Master reset low resets, outputs off
// - Master reset high releases and enables outputs
// - Invert select flips bank C outputs 2,3
// - Serial line shifted on serial shift clock
// - Serial bits gate individual outputs
// - Zero start bit then twelve bits, rising edges
// - Bit map A, B, C1-3, sync pulse
// - Zero freezes low, one enables, no runts
// - Sync rise meets common A and C rise
`timescale 1ns/1ps
module mbcd_top (
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   // Reference and loop pins
   input  wire logic                diff_ref_in,
   input  wire logic                ref_clk_0,
   input  wire logic                ref_clk_1,
   input  wire logic                loop_return_in,
   // Straps
   input  wire mbcd_pkg::mbcd_sel_s sel_pins,
   input  wire logic                master_reset_oe,
   // Serial freeze port
   input  wire logic                serial_shift_clock,
   input  wire logic                serial_in_line,
   // Clock outputs
   output logic [3:0]               bank_a_out,
   output logic [3:0]               bank_b_out,
   output logic [3:0]               bank_c_out,
   output logic                     loop_return_out,
   output logic                     coincidence_pulse_out,
   output logic                     loop_return_match
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   mbcd_pkg::mbcd_sel_s sel_m_q, sel_q;
   logic [5:0]          pin_m_q, pin_q;
   logic                mr_m_q, mr_q;
   logic                run_b;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sel_m_q <= '0;
         sel_q   <= '0;
         pin_m_q <= 6'h00;
         pin_q   <= 6'h00;
         mr_m_q  <= 1'b0;
         mr_q    <= 1'b0;
      end else begin
         sel_m_q <= sel_pins;
         sel_q   <= sel_m_q;
         pin_m_q <= {diff_ref_in, ref_clk_0, ref_clk_1, loop_return_in,
                     serial_shift_clock, serial_in_line};
         pin_q   <= pin_m_q;
         mr_m_q  <= master_reset_oe;
         mr_q    <= mr_m_q;
      end
   end

   // Whole core held while the master reset pin is low
   assign run_b = rst_b & mr_q;

   ////////////////////////////////////////////////////////////////////
   // Reference choice and VCO tick
   logic ref_d, ref_q, ref_rise, vco_tick, pre_q, halve_q, div_tick;

   always_comb begin
      if (sel_q.ref_source_sel)
         ref_d = pin_q[5];
      else if (sel_q.test_ref_sel)
         ref_d = pin_q[3];
      else
         ref_d = pin_q[4];
   end

   assign ref_rise = ref_d & ~ref_q;
   // Bypass: reference edges replace the VCO
   assign vco_tick = sel_q.loop_enable ? 1'b1 : ref_rise;
   assign div_tick = vco_tick & (halve_q | pre_q);

   always_ff @(posedge sys_clk) begin
      if (!run_b) begin
         ref_q   <= 1'b0;
         pre_q   <= 1'b0;
         halve_q <= 1'b0;
      end else begin
         ref_q <= ref_d;
         if (vco_tick) begin
            pre_q <= ~pre_q & ~halve_q;
            // Halve mode swapped only at a prescaler boundary
            if (!pre_q)
               halve_q <= sel_q.vco_halve_sel;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!run_b)
         loop_return_match <= 1'b0;
      else if (ref_rise)
         loop_return_match <= pin_q[2];
   end

   ////////////////////////////////////////////////////////////////////
   // Dividers
   logic                lvl_a, lvl_b, lvl_c, lvl_f;
   mbcd_pkg::mbcd_per_t rem_a, rem_c, per_a, per_c, pf;

   mbcd_divider u_div_a (
      .sys_clk  (sys_clk),
      .run_b    (run_b),
      .tick     (div_tick),
      .half_new (mbcd_pkg::BANK_A_HALF[sel_q.bank_a_sel]),
      .level_d  (lvl_a),
      .rem_d    (rem_a),
      .per_d    (per_a)
   );

   mbcd_divider u_div_b (
      .sys_clk  (sys_clk),
      .run_b    (run_b),
      .tick     (div_tick),
      .half_new (mbcd_pkg::BANK_B_HALF[sel_q.bank_b_sel]),
      .level_d  (lvl_b),
      .rem_d    (),
      .per_d    ()
   );

   mbcd_divider u_div_c (
      .sys_clk  (sys_clk),
      .run_b    (run_b),
      .tick     (div_tick),
      .half_new (mbcd_pkg::BANK_C_HALF[sel_q.bank_c_sel]),
      .level_d  (lvl_c),
      .rem_d    (rem_c),
      .per_d    (per_c)
   );

   mbcd_divider u_div_f (
      .sys_clk  (sys_clk),
      .run_b    (run_b),
      .tick     (div_tick),
      .half_new (mbcd_pkg::LOOP_HALF[sel_q.loop_ratio_sel]),
      .level_d  (lvl_f),
      .rem_d    (),
      .per_d    ()
   );

   ////////////////////////////////////////////////////////////////////
   // Sync: low for the last fast period before a common A/C rise
   logic sync_d;

   assign pf     = (per_a < per_c) ? per_a : per_c;
   assign sync_d = ~((rem_a == rem_c) && (rem_a <= pf) && (rem_a != per_a));

   ////////////////////////////////////////////////////////////////////
   // Serial freeze port
   mbcd_pkg::mbcd_ser_e     ser_q;
   logic                    sclk_q, sclk_rise;
   logic [mbcd_pkg::CNT_W-1:0]   bit_q;
   logic [mbcd_pkg::NUM_FRZ-1:0] shift_q, frz_q;

   assign sclk_rise = pin_q[1] & ~sclk_q;

   always_ff @(posedge sys_clk) begin
      if (!run_b) begin
         ser_q   <= mbcd_pkg::SER_IDLE;
         sclk_q  <= 1'b0;
         bit_q   <= '0;
         shift_q <= '0;
         frz_q   <= mbcd_pkg::FRZ_RESET;
      end else begin
         sclk_q <= pin_q[1];
         case (ser_q)
            mbcd_pkg::SER_IDLE: begin
               if (sclk_rise && pin_q[0] == mbcd_pkg::START_LVL) begin
                  ser_q <= mbcd_pkg::SER_SHIFT;
                  bit_q <= '0;
               end
            end
            mbcd_pkg::SER_SHIFT: begin
               if (sclk_rise) begin
                  shift_q[bit_q] <= pin_q[0];
                  bit_q          <= bit_q + 4'h1;
                  if (bit_q == mbcd_pkg::LAST_BIT)
                     ser_q <= mbcd_pkg::SER_LOAD;
               end
            end
            mbcd_pkg::SER_LOAD: begin
               frz_q <= shift_q;
               ser_q <= mbcd_pkg::SER_IDLE;
            end
            default: ser_q <= mbcd_pkg::SER_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output gating; enables move only while the raw level is low
   // Only the twelve freezable outputs; C0 and loop return stay outside
   logic [mbcd_pkg::NUM_FRZ-1:0] raw_d, en_q, gated_d;
   logic                         c2_d, c3_d;

   assign c2_d  = lvl_c ^ sel_q.invert_sel;
   assign c3_d  = lvl_c ^ sel_q.invert_sel;
   assign raw_d = {sync_d, c3_d, c2_d, lvl_c, {4{lvl_b}}, {4{lvl_a}}};

   always_ff @(posedge sys_clk) begin
      if (!run_b) begin
         en_q <= mbcd_pkg::FRZ_RESET;
      end else begin
         for (int i = 0; i < mbcd_pkg::NUM_FRZ; i++) begin
            if (!raw_d[i])
               en_q[i] <= frz_q[i];
         end
      end
   end

   assign gated_d = raw_d & en_q;

   always_ff @(posedge sys_clk) begin
      if (!run_b) begin
         bank_a_out            <= 4'h0;
         bank_b_out            <= 4'h0;
         bank_c_out            <= 4'h0;
         loop_return_out       <= 1'b0;
         coincidence_pulse_out <= 1'b0;
      end else begin
         bank_a_out            <= gated_d[mbcd_pkg::FRZ_A_LO +: 4];
         bank_b_out            <= gated_d[mbcd_pkg::FRZ_B_LO +: 4];
         // Bank C output 0 and loop return are never frozen
         bank_c_out            <= {gated_d[mbcd_pkg::FRZ_C_LO +: 3], lvl_c};
         loop_return_out       <= lvl_f;
         coincidence_pulse_out <= gated_d[mbcd_pkg::FRZ_SYNC];
      end
   end

endmodule

// File: tb.sv
// Bench for mbcd_top: ratio table, bypass, invert, freeze, resets.
// Assumes mbcd_board on the pins and mbcd_monitor bound to the top.
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [6:0]  sel;
      logic [2:0]  l;
      logic [31:0] per;
   } mbcd_row_s;
   // Halve, A, B, C select; loop code; loop, C, B, A periods
   localparam mbcd_row_s ROWS [8] = '{
      '{7'h40, 3'h0, 32'h04020404}, '{7'h3F, 3'h7, 32'h28101418},
      '{7'h5B, 3'h5, 32'h0C080806}, '{7'h25, 3'h6, 32'h20080C10},
      '{7'h7E, 3'h3, 32'h0A060A0C}, '{7'h1A, 3'h1, 32'h0C0C100C},
      '{7'h00, 3'h2, 32'h10040808}, '{7'h64, 3'h4, 32'h08020608}};
   logic                sys_clk = 1'b0;
   logic                rst_b = 1'b0;
   logic                master_reset_oe = 1'b1;
   logic                send = 1'b0;
   logic [11:0]         frame = 12'hFFF;
   mbcd_pkg::mbcd_sel_s sel_pins = 14'h2006;
   logic [2:0]          refs;
   logic                sclk;
   logic                sdat;
   logic                busy;
   logic [3:0]          qa;
   logic [3:0]          qb;
   logic [3:0]          qc;
   logic                qfb;
   logic                lrm;
   logic [7:0]          per;
   logic [12:0]         seen;
   int                  mismatches = 0;
   int                  checked = 0;
   int                  cycles = 0;
   wire  [3:0]          mon = {qfb, qc[0], qb[0], qa[0]};
   wire  [12:0]         outs = {qc, qb, qa, qfb};
   ////////////////////////////////////////
   always #50 sys_clk = ~sys_clk;
   mbcd_board brd (.sys_clk(sys_clk), .send(send), .frame(frame),
      .serial_shift_clock(sclk), .serial_in_line(sdat), .busy(busy), .refs(refs));
   mbcd_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .diff_ref_in(refs[0]),
      .ref_clk_0(refs[1]), .ref_clk_1(refs[2]), .loop_return_in(qfb),
      .sel_pins(sel_pins), .master_reset_oe(master_reset_oe),
      .serial_shift_clock(sclk), .serial_in_line(sdat), .bank_a_out(qa),
      .bank_b_out(qb), .bank_c_out(qc), .loop_return_out(qfb),
      .coincidence_pulse_out(), .loop_return_match(lrm));
   task automatic check(input logic [12:0] s, input logic [12:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Rise to rise, sampled at the settled falling edge
   task automatic period(input int i, output logic [7:0] p);
      @(negedge sys_clk iff !mon[i]);
      @(negedge sys_clk iff mon[i]);
      p = 8'h00;
      do begin @(negedge sys_clk); p++; end while (mon[i]);
      do begin @(negedge sys_clk); p++; end while (!mon[i] && p < 8'hC8);
   endtask
   task automatic watch(output logic [12:0] s);
      s = 13'h0000;
      repeat (40) begin @(negedge sys_clk); s = s | outs; end
   endtask
   task automatic load(input logic [11:0] f);
      @(posedge sys_clk);
      frame <= f;
      send <= 1'b1;
      @(negedge sys_clk iff busy);
      @(posedge sys_clk);
      send <= 1'b0;
      @(negedge sys_clk iff !busy);
      repeat (30) @(posedge sys_clk);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (ROWS[n]) begin
         @(posedge sys_clk);
         {sel_pins.vco_halve_sel, sel_pins.bank_a_sel, sel_pins.bank_b_sel,
            sel_pins.bank_c_sel} <= ROWS[n].sel;
         sel_pins.loop_ratio_sel <= ROWS[n].l;
         repeat (90) @(posedge sys_clk);
         for (int i = 0; i < 4; i++) begin
            period(i, per);
            check({5'h00, per}, {5'h00, ROWS[n].per[i*8 +: 8]});
         end
      end
      for (int r = 0; r < 3; r++) begin
         @(posedge sys_clk);
         sel_pins.loop_enable <= 1'b0;
         sel_pins.ref_source_sel <= (r == 0);
         sel_pins.test_ref_sel <= (r == 2);
         repeat (150) @(posedge sys_clk);
         period(1, per);
         // Bank B code 01 halved: six reference rises per period
         check({5'h00, per}, 13'h0030 << r);
         // Loop return sampled at reference rises must show both levels
         seen = 13'h0000;
         repeat (70 << r) begin
            @(negedge sys_clk);
            seen[lrm] = 1'b1;
         end
         check(seen, 13'h0003);
      end
      @(posedge sys_clk);
      sel_pins.loop_enable <= 1'b1;
      sel_pins.invert_sel <= 1'b1;
      repeat (60) @(posedge sys_clk);
      @(negedge sys_clk iff qc[0]);
      check({11'h000, qc[3:2]}, 13'h0000);
      @(negedge sys_clk iff !qc[0]);
      check({11'h000, qc[3:2]}, 13'h0003);
      @(posedge sys_clk);
      sel_pins.invert_sel <= 1'b0;
      load(12'hD0D);
      watch(seen);
      check(seen, 13'h161B);
      @(posedge sys_clk);
      master_reset_oe <= 1'b0;
      repeat (6) @(posedge sys_clk);
      watch(seen);
      check(seen, 13'h0000);
      @(posedge sys_clk);
      master_reset_oe <= 1'b1;
      watch(seen);
      check(seen, 13'h1FFF);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check(outs, 13'h0000);
      @(posedge sys_clk);
      rst_b <= 1'b1;
      watch(seen);
      check(seen, 13'h1FFF);
      summarize();
   end
endmodule
